// File: dv/microcycle_clock_controller_tb_top.sv
// Self-checking bench for the microcycle clock controller
`timescale 1ns/1ps
`default_nettype none
module microcycle_clock_controller_tb_top;
    localparam int DIV = 2; // Oscillator divider
    // Stimulus
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic run_n = 1'b1;
    logic halt_n = 1'b1;
    logic step_open = 1'b0;
    logic step_closed = 1'b1;
    logic halt_first = 1'b0;
    logic seq_en = 1'b0;
    logic use_p3 = 1'b0;
    logic want = 1'b0;
    logic [7:0] slow = 8'h0C;
    // Observed nets
    logic [2:0] code;
    logic sel, req_n, rdy_n, ack_n, osc, p1, p2, p3, p4, halted;
    logic [3:0] phs;
    // Edge ages and bookkeeping
    logic sel_q = 1'b1;
    logic rdy_q = 1'b1;
    int sel_age = 0;
    int rdy_age = 0;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    assign phs = {p1, p2, p3, p4};
    // Clock
    always #2.5 ref_clk = ~ref_clk;
    // Ages since select and ready fell, plus hang guard
    always @(posedge ref_clk) begin
        sel_q <= sel;
        rdy_q <= rdy_n;
        sel_age <= (sel_q === 1'b1 && sel === 1'b0) ? 0 : sel_age + 1;
        rdy_age <= (rdy_q === 1'b1 && rdy_n === 1'b0) ? 0 : rdy_age + 1;
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            failures++;
            final_report();
        end
    end
    microcycle_clock_controller #(.OSC_DIV(DIV)) u_dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst),
        .length_sel_0(code[0]), .length_sel_1(code[1]), .length_sel_2(code[2]),
        .run_n(run_n), .halt_n(halt_n), .step_switch_open(step_open),
        .step_switch_closed(step_closed), .halt_at_first(halt_first),
        .stretch_request_n(req_n), .stretch_sample_select(sel), .ready_n(rdy_n),
        .stretch_ack_n(ack_n), .osc_clock_out(osc),
        .phase_1(p1), .phase_2(p2), .phase_3(p3), .phase_4(p4), .halted(halted)
    );
    microcycle_partner u_partner (
        .ref_clk(ref_clk), .phase_1(p1), .phase_3(p3), .stretch_ack_n(ack_n),
        .seq_en(seq_en), .use_phase_3(use_p3), .want_stretch(want), .slow_cycles(slow),
        .length_code(code), .stretch_sample_select(sel), .stretch_request_n(req_n), .ready_n(rdy_n)
    );
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Advance n edges, then step off the edge
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Bounded wait for phase 1 level
    task automatic wait_p1(input logic v);
        for (int i = 0; i < 100 && p1 !== v; i++) tick(1);
    endtask
    // Shape and length of successive microcycles, code changing each cycle
    task automatic t_length;
        int len, lo1, lo4, lo2, hi3, lack, exp_len;
        logic [2:0] nxt;
        logic q;
        seq_en = 1'b1;
        nxt = 3'h0;
        wait_p1(1'b0);
        wait_p1(1'b1);
        for (int k = 0; k < 9; k++) begin
            exp_len = (3 + nxt) * DIV;
            len = 0; lo1 = 0; lo4 = 0; lo2 = 0; hi3 = 0; lack = 0;
            do begin
                q = p1;
                tick(1);
                len++;
                lo1 += (p1 === 1'b0);
                lo4 += (p4 === 1'b0);
                lo2 += (p2 === 1'b0);
                hi3 += (p3 === 1'b1);
                lack += (ack_n !== 1'b1);
                // Code seen in the last period governs the next cycle
                if (p1 === 1'b0) nxt = code;
            end while (!(q === 1'b0 && p1 === 1'b1) && len < 60);
            if (k > 0) begin
                check(len, exp_len);
                check(lo1, DIV);
                check(lo4, DIV);
                check(lo2, 2 * DIV);
                check(2 * hi3 >= len - DIV && 2 * hi3 <= len + DIV, 1);
                check(lack, 0);
            end
        end
    endtask
    // Halt, freeze, single step, then resume
    task automatic t_halt(input logic f);
        logic [3:0] ph;
        logic o;
        int bad, tog, falls;
        halt_first = f;
        halt_n = 1'b0;
        for (int i = 0; i < 100 && halted !== 1'b1; i++) tick(1);
        // Release: latch must keep the halt
        halt_n = 1'b1;
        tick(8);
        check(halted, 1);
        check(phs, f ? 4'hE : 4'h1);
        ph = phs; o = osc; bad = 0; tog = 0;
        for (int i = 0; i < 20; i++) begin
            tick(1);
            bad += (phs !== ph);
            tog += (osc !== o);
            o = osc;
        end
        check(bad, 0);
        check(tog, 40 / DIV);
        // Break-before-make press and release of the step switch
        falls = 0;
        for (int i = 0; i < 80; i++) begin
            step_closed = (i < 2 || i > 7);
            step_open = (i >= 3 && i < 6);
            o = p4;
            tick(1);
            falls += (o === 1'b1 && p4 === 1'b0);
        end
        check(falls, 1);
        check({halted, phs}, {1'b1, f ? 4'hE : 4'h1});
        run_n = 1'b0;
        tick(4);
        run_n = 1'b1;
        for (int i = 0; i < 100 && phs === ph; i++) tick(1);
        check({halted, phs !== ph}, 2'b01);
    endtask
    // Stretch with a slow peripheral at one sample point
    task automatic t_stretch(input logic s);
        logic [3:0] ph;
        int bad, n;
        use_p3 = s;
        tick(4);
        want = 1'b1;
        for (int i = 0; i < 100 && ack_n !== 1'b0; i++) tick(1);
        check(ack_n, 0);
        check(sel_age <= 3 * DIV + 4, 1);
        tick(1);
        ph = phs; bad = 0; n = 0;
        while (ack_n === 1'b0 && n < 200) begin
            bad += (phs !== ph);
            n++;
            tick(1);
        end
        check(bad, 0);
        check(n >= slow, 1);
        check(rdy_age >= DIV && rdy_age <= 3 * DIV + 4, 1);
        for (int i = 0; i < 40 && phs === ph; i++) tick(1);
        check(phs !== ph, 1);
        want = 1'b0;
    endtask
    // Counts and verdict, then stop
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        tick(4);
        sys_rst = 1'b0;
        tick(4);
        t_length();
        t_halt(1'b0);
        t_halt(1'b1);
        t_stretch(1'b0);
        t_stretch(1'b1);
        final_report();
    end
endmodule
`default_nettype wire

// File: dv/microcycle_partner.sv
// Far side model: microprogram sequencer plus one slow peripheral
`timescale 1ns/1ps
`default_nettype none
module microcycle_partner (
    // Clock
    input wire logic ref_clk,
    // Controller outputs
    input wire logic phase_1,
    input wire logic phase_3,
    input wire logic stretch_ack_n,
    // Scenario control
    input wire logic seq_en,
    input wire logic use_phase_3,
    input wire logic want_stretch,
    input wire logic [7:0] slow_cycles,
    // Pins into the controller
    output logic [2:0] length_code,
    output logic stretch_sample_select,
    output logic stretch_request_n,
    output logic ready_n
);
    logic [2:0] word_ptr = 3'h0; // Microword index
    logic prev_p1 = 1'b1; // Phase 1 one cycle back
    logic acked = 1'b0; // Stretch granted
    logic [7:0] busy = 8'h00; // Peripheral busy count
    // Idle pin levels
    initial begin
        length_code = 3'h0;
        stretch_sample_select = 1'b1;
        stretch_request_n = 1'b1;
        ready_n = 1'b1;
    end
    // All pins move just after the rising edge
    always @(posedge ref_clk) begin
        #1;
        // New microword with each new microcycle, all eight codes in turn
        if (seq_en && prev_p1 === 1'b0 && phase_1 === 1'b1) begin
            length_code = word_ptr * 3'h5 + 3'h2;
            word_ptr = word_ptr + 3'h1;
        end
        prev_p1 = phase_1;
        // Sample point wired to a phase output
        stretch_sample_select = use_phase_3 ? phase_3 : phase_1;
        // Peripheral handshake
        if (!want_stretch) begin
            stretch_request_n = 1'b1;
            ready_n = 1'b1;
            acked = 1'b0;
        end else if (!acked) begin
            stretch_request_n = 1'b0;
            if (stretch_ack_n === 1'b0) begin
                acked = 1'b1;
                busy = slow_cycles;
            end
        end else if (busy != 8'h00) begin
            busy = busy - 8'h01;
        end else if (stretch_ack_n === 1'b1) begin
            // Released: go idle until asked again
            stretch_request_n = 1'b1;
            ready_n = 1'b1;
        end else begin
            ready_n = 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: hw/microcycle_clock_controller.sv
// Programmable microcycle clock generator with run, halt, step and stretch control
//
// Summary of operation
// R1: Length code picks three to ten periods
// R2: Length code latched at end of each microcycle
// R3: Length code shares microword with its instruction
// R4: Run, halt, step switches pass debounce latches
// R5: Halt stops on first or last state
// R6: Run low with halt high resumes running
// R7: Peripheral drives stretch request low for wait
// R8: Sample select sets when request is sampled
// R9: Peripheral drives ready low to finish cycle
// R10: Ack low after select falls, until ready+2
// R11: Step switches run exactly one microcycle
// R12: Step high one edge starts run, stops
// R13: Oscillator clocks all; copy driven out
// R14: Phase 1 marks control latch load point
// R15: Phase 1 low last, phase 4 first
// R16: Phase 3 roughly half the microcycle
// R17: Next state loaded on internal falling edge
// R18: Phases hold while stretch ack low
// R19: Halt freezes phases, oscillator copy runs
`timescale 1ns/1ps
`default_nettype none
module microcycle_clock_controller #(
    parameter int OSC_DIV = microcycle_pkg::OSC_DIV_DEFAULT
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Microword length code
    input wire logic length_sel_0,
    input wire logic length_sel_1,
    input wire logic length_sel_2,
    // Front panel switches
    input wire logic run_n,
    input wire logic halt_n,
    input wire logic step_switch_open,
    input wire logic step_switch_closed,
    input wire logic halt_at_first,
    // Stretch handshake
    input wire logic stretch_request_n,
    input wire logic stretch_sample_select,
    input wire logic ready_n,
    output logic stretch_ack_n,
    // Clock outputs
    output logic osc_clock_out,
    output logic phase_1,
    output logic phase_2,
    output logic phase_3,
    output logic phase_4,
    // Status
    output logic halted
);
    // Refuse a divider that cannot form a high and a low half
    if (OSC_DIV < 2 || OSC_DIV > 256) begin : g_div_check
        $error("OSC_DIV must lie between 2 and 256");
    end

    localparam int SYNC_W = 7;
    localparam logic [7:0] DIV_LAST = 8'(OSC_DIV - 1);
    localparam logic [7:0] DIV_HALF = 8'(OSC_DIV / 2);
    localparam int OSC_MAX = OSC_DIV;
    localparam int HALT_MAX = 12 * OSC_DIV;

    logic [SYNC_W-1:0] pin_raw; // Plain pins needing synchronisation
    logic [SYNC_W-1:0] pin_s1_ff; // First synchroniser stage
    logic [SYNC_W-1:0] pin_s2_ff; // Second synchroniser stage, safe to use
    logic [7:0] div_ff; // Oscillator period divider
    logic osc_tick; // One-cycle enable at the internal falling edge
    logic osc_out_ff; // Buffered oscillator copy
    logic [2:0] len_sel_ff; // Microcycle control latch
    localparam int POS_W_L = microcycle_pkg::POS_W;
    logic [POS_W_L-1:0] pos_ff; // Position within the microcycle
    logic [3:0] len; // Current microcycle length
    logic [3:0] last_pos; // Position of the final state
    logic [3:0] nxt_pos; // Position after the next advance
    logic [3:0] halt_pt; // Position at which a halt settles
    logic [3:0] phase_ff; // Phase register, bit 0 is phase 1
    logic [3:0] nxt_phase; // Phase pattern for nxt_pos
    logic advance; // Phase register moves this cycle
    logic halt_db; // Debounced halt latch, clear after reset so the block starts running
    logic run_db; // Run requested: halt latch clear
    logic step_db; // Debounced step latch
    logic step_prev_ff; // Step latch as seen at the previous tick
    logic cx_prev_ff; // Sample select as seen at the previous tick
    logic ack_n_ff; // Stretch acknowledge, active low
    logic [1:0] ready_cnt_ff; // Ticks with ready low during a stretch
    logic ack_set; // Stretch begins this tick
    microcycle_pkg::mode_type mode_ff; // Run, halt or step mode

    assign pin_raw = {halt_at_first, ready_n, stretch_sample_select, stretch_request_n,
                      length_sel_2, length_sel_1, length_sel_0};

    // Two flip-flops per pin before any logic looks at it
    for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
        always_ff @(posedge ref_clk) begin
            if (sys_rst) begin
                pin_s1_ff[i] <= 1'b1;
                pin_s2_ff[i] <= 1'b1;
            end else begin
                pin_s1_ff[i] <= pin_raw[i];
                pin_s2_ff[i] <= pin_s1_ff[i];
            end
        end
    end

    // Run/halt pair and the step contact pair each form a debounce latch
    switch_latch #(.SET_ACTIVE(1'b0), .CLR_ACTIVE(1'b0)) u_run_latch ( // R4
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .set_pin(halt_n),
        .clr_pin(run_n),
        .latched_ff(halt_db)
    );
    // Latch holds the halt request, so reset leaves the machine running
    assign run_db = !halt_db;
    switch_latch #(.SET_ACTIVE(1'b1), .CLR_ACTIVE(1'b1)) u_step_latch ( // R4
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .set_pin(step_switch_open),
        .clr_pin(step_switch_closed),
        .latched_ff(step_db)
    );

    // Oscillator divider; the tick is where the buffered copy rises
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            div_ff <= 8'h00;
            osc_out_ff <= 1'b1;
        end else begin
            div_ff <= osc_tick ? 8'h00 : div_ff + 8'h01;
            osc_out_ff <= osc_tick || (div_ff + 8'h01 < DIV_HALF); // R13
        end
    end
    assign osc_tick = (div_ff == DIV_LAST);

    // Length arithmetic for the latched code
    assign len = microcycle_pkg::LEN_BASE + {1'b0, len_sel_ff}; // R1
    assign last_pos = len - 4'h1;
    assign nxt_pos = (pos_ff == last_pos) ? 4'h0 : pos_ff + 4'h1;
    assign halt_pt = pin_s2_ff[6] ? 4'h0 : last_pos; // R5

    // Phase shapes for a given position and length
    always_comb begin
        nxt_phase[0] = (nxt_pos != nxt_len_last()); // R15
        nxt_phase[1] = ({1'b0, nxt_pos} + 5'h2 < {1'b0, nxt_len()}); // R15
        nxt_phase[2] = ({nxt_pos, 1'b0} < {1'b0, nxt_len()} - 5'h1); // R16
        nxt_phase[3] = (nxt_pos != 4'h0); // R15
    end

    // Length that applies after the advance: new code at a cycle boundary
    function automatic logic [3:0] nxt_len();
        if (pos_ff == last_pos) begin
            nxt_len = microcycle_pkg::LEN_BASE + {1'b0, pin_s2_ff[2:0]};
        end else begin
            nxt_len = len;
        end
    endfunction
    function automatic logic [3:0] nxt_len_last();
        nxt_len_last = nxt_len() - 4'h1;
    endfunction

    // Phases move only on a tick outside halt and outside a stretch
    assign advance = osc_tick && mode_ff != microcycle_pkg::MODE_HALT
                     && ack_n_ff && !ack_set; // R18 R19

    // Control latch loads while phase 1 is low, i.e. on leaving the last state
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            len_sel_ff <= microcycle_pkg::LEN_SEL_RESET;
        end else if (advance && !phase_ff[0]) begin
            len_sel_ff <= pin_s2_ff[2:0]; // R2 R14
        end
    end

    // Current-state register loads at the internal falling edge
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pos_ff <= 4'h0;
            phase_ff <= microcycle_pkg::PHASE_RESET;
        end else if (advance) begin
            pos_ff <= nxt_pos; // R17
            phase_ff <= nxt_phase;
        end
    end

    // Stretch handshake: sample request (bit 3) when select (bit 4) falls, release after ready
    assign ack_set = osc_tick && ack_n_ff && cx_prev_ff && !pin_s2_ff[4] && !pin_s2_ff[3]; // R8
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cx_prev_ff <= 1'b1;
            ack_n_ff <= 1'b1;
            ready_cnt_ff <= 2'h0;
        end else if (osc_tick) begin
            cx_prev_ff <= pin_s2_ff[4];
            if (ack_set) begin
                ack_n_ff <= 1'b0; // R10
                ready_cnt_ff <= 2'h0;
            end else if (!ack_n_ff) begin
                if (ready_low() && ready_cnt_ff + 2'h1 == microcycle_pkg::READY_RELEASE_TICKS) begin
                    // Second tick with ready low ends the stretch
                    ack_n_ff <= 1'b1; // R10
                    ready_cnt_ff <= 2'h0;
                end else begin
                    // Count ticks with ready low; ready high restarts the count
                    ready_cnt_ff <= ready_low() ? ready_cnt_ff + 2'h1 : 2'h0;
                end
            end
        end
    end
    // Synchronised ready pin, active low
    function automatic logic ready_low();
        ready_low = !pin_s2_ff[5];
    endfunction

    // Mode machine: halt at the chosen point, resume on run, one cycle per step
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            mode_ff <= microcycle_pkg::MODE_RUN;
            step_prev_ff <= 1'b0;
        end else if (osc_tick) begin
            step_prev_ff <= step_db;
            case (mode_ff)
                microcycle_pkg::MODE_RUN: begin
                    if (advance && !run_db && nxt_pos == halt_pt) begin
                        mode_ff <= microcycle_pkg::MODE_HALT; // R5
                    end
                end
                microcycle_pkg::MODE_HALT: begin
                    if (run_db) begin
                        mode_ff <= microcycle_pkg::MODE_RUN; // R6
                    end else if (step_db && !step_prev_ff) begin
                        mode_ff <= microcycle_pkg::MODE_STEP; // R11 R12
                    end
                end
                microcycle_pkg::MODE_STEP: begin
                    if (run_db) begin
                        mode_ff <= microcycle_pkg::MODE_RUN;
                    end else if (advance && nxt_pos == halt_pt) begin
                        mode_ff <= microcycle_pkg::MODE_HALT; // R11 R12
                    end
                end
                default: begin
                    mode_ff <= microcycle_pkg::MODE_RUN;
                end
            endcase
        end
    end

    // Outputs straight from flip-flops
    assign osc_clock_out = osc_out_ff;
    assign phase_1 = phase_ff[0];
    assign phase_2 = phase_ff[1];
    assign phase_3 = phase_ff[2];
    assign phase_4 = phase_ff[3];
    assign stretch_ack_n = ack_n_ff;
    // Only the halt code has bit 0 set, so the flag is a plain flop bit
    assign halted = mode_ff[0];

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_last_state;
        !phase_1 |-> !phase_2 && !phase_3 && phase_4;
    endproperty
    a_last_state: assert property (p_last_state) else $error("last state shape wrong"); // R15
    property p_first_state;
        !phase_4 |-> phase_1 && phase_2;
    endproperty
    a_first_state: assert property (p_first_state) else $error("first state shape wrong"); // R15
    property p_len_range;
        pos_ff < len && len <= 4'hA;
    endproperty
    a_len_range: assert property (p_len_range) else $error("position beyond length"); // R1
    property p_latch_at_end;
        $changed(len_sel_ff) |-> $past(advance) && !$past(phase_ff[0]);
    endproperty
    a_latch_at_end: assert property (p_latch_at_end) else $error("latch moved mid cycle"); // R2
    property p_stretch_hold;
        !stretch_ack_n && $past(!stretch_ack_n) |-> $stable(phase_ff);
    endproperty
    a_stretch_hold: assert property (p_stretch_hold) else $error("phase moved during stretch"); // R18
    property p_halt_hold;
        halted && $past(halted) |-> $stable(phase_ff);
    endproperty
    a_halt_hold: assert property (p_halt_hold) else $error("phase moved while halted"); // R19
    property p_osc_runs;
        osc_clock_out |-> ##[1:OSC_MAX] !osc_clock_out;
    endproperty
    a_osc_runs: assert property (p_osc_runs) else $error("oscillator copy stuck"); // R13
    property p_resume;
        halted && run_db |-> ##[1:OSC_MAX] !halted;
    endproperty
    a_resume: assert property (p_resume) else $error("run did not resume"); // R6
    property p_halt_point;
        $rose(halted) |-> (pos_ff == $past(halt_pt));
    endproperty
    a_halt_point: assert property (p_halt_point) else $error("halted off the halt point"); // R5
    property p_ack_release;
        $rose(stretch_ack_n) |-> $past(ready_cnt_ff) == 2'h1;
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("ack released early"); // R10
    property p_step_leaves;
        halted && step_db && !step_prev_ff && !run_db && osc_tick |=> !halted ##[1:HALT_MAX] halted;
    endproperty
    a_step_leaves: assert property (p_step_leaves) else $error("step did not run one cycle"); // R11
endmodule
`default_nettype wire

// File: hw/switch_latch.sv
// Synchronised set-reset latch that debounces a pair of switch contacts
`timescale 1ns/1ps
`default_nettype none
module switch_latch #(
    parameter logic SET_ACTIVE = 1'b0,
    parameter logic CLR_ACTIVE = 1'b0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // Contact pins
    input wire logic set_pin,
    input wire logic clr_pin,
    // Debounced level
    output logic latched_ff
);
    logic [1:0] set_sync_ff; // Two-stage synchroniser for the set contact
    logic [1:0] clr_sync_ff; // Two-stage synchroniser for the clear contact

    // Bring both contacts into the clock domain
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            set_sync_ff <= {~SET_ACTIVE, ~SET_ACTIVE};
            clr_sync_ff <= {~CLR_ACTIVE, ~CLR_ACTIVE};
        end else begin
            set_sync_ff <= {set_sync_ff[0], set_pin};
            clr_sync_ff <= {clr_sync_ff[0], clr_pin};
        end
    end

    // Bounce on one contact cannot change the level; only the other contact can
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            latched_ff <= 1'b0;
        end else if (set_sync_ff[1] == SET_ACTIVE && clr_sync_ff[1] != CLR_ACTIVE) begin
            latched_ff <= 1'b1;
        end else if (clr_sync_ff[1] == CLR_ACTIVE && set_sync_ff[1] != SET_ACTIVE) begin
            latched_ff <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: pkg/microcycle_pkg.sv
// Shared constants and types for the microcycle clock controller
package microcycle_pkg;
    // Width of the microcycle length code
    localparam int LEN_SEL_W = 3;
    // Width of the position counter inside a microcycle
    localparam int POS_W = 4;
    // Shortest microcycle, in oscillator periods
    localparam logic [3:0] LEN_BASE = 4'h3;
    // Length code held in the control latch after reset
    localparam logic [2:0] LEN_SEL_RESET = 3'h0;
    // Default number of ref_clk cycles per oscillator period
    localparam int OSC_DIV_DEFAULT = 2;
    // Oscillator periods with ready low before the stretch ends
    localparam logic [1:0] READY_RELEASE_TICKS = 2'h2;
    // Phase pattern held after reset: the first state of a cycle
    localparam logic [3:0] PHASE_RESET = 4'h7;
    // Mode state machine
    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_HALT = 2'b01,
        MODE_STEP = 2'b10
    } mode_type;
endpackage
